// File: hw/host_bus_port.sv
// Asynchronous host bus port: register cycles, vectored acknowledge, reset and DMA ready pins
`default_nettype none
module host_bus_port import host_port_pkg::*; #(
  parameter int SOURCES = NUM_SOURCES  // Interrupt channels served
) (
  input wire logic clk_sys,                     // System clock
  input wire logic reset,                       // Synchronous reset, high
  // Host bus pins
  input wire logic chip_sel_n,                  // Chip select, low
  input wire logic data_strobe_n,               // Data strobe, low
  input wire logic read_write,                  // High read, low write
  input wire logic [4:0] reg_select,            // Register select bus
  input wire logic [7:0] data_in,               // Data bus input
  output logic [7:0] data_out,                  // Data bus output
  output logic data_oe,                         // Data bus drive enable
  output logic transfer_ack_n,                  // Acknowledge level
  output logic transfer_ack_oe,                 // Acknowledge drive enable
  input wire logic int_ack_n,                   // Interrupt acknowledge, low
  input wire logic chain_enable_in_n,           // Chain enable in, low
  output logic chain_enable_out_n,              // Chain enable out, low
  output logic irq_out,                         // Open-drain request level
  output logic irq_oe,                          // Request pull-down enable
  // Register file side
  output logic reg_rd,                          // Read request pulse
  output logic reg_wr,                          // Write strobe pulse
  output logic [4:0] reg_addr,                  // Selected register
  output logic [7:0] reg_wdata,                 // Write data
  input wire logic [7:0] reg_rdata,             // Read data, valid in the same cycle that reg_rd is high
  output logic [7:0] vector_base_reg,           // Vector base register
  // Interrupt controller side
  input wire logic [SOURCES-1:0] int_pending,   // Enabled, unmasked pending sources
  output logic vec_taken,                       // Vector delivered pulse
  output logic [CHAN_W-1:0] vec_channel,        // Channel whose vector was taken
  output logic core_clear,                      // Clears non-retained registers
  // Timers, port and serial side
  input wire logic timer_run_req,               // Timers wish to run
  output logic timer_run,                       // Timers allowed to run
  input wire logic [3:0] timer_out_in,          // Raw timer outputs
  output logic [3:0] timer_out,                 // Timer output pins
  input wire logic [7:0] gpio_dir,              // Port direction, one drives
  output logic [7:0] gpio_oe,                   // Port drive enables
  input wire logic serial_en_req,               // Receiver/transmitter enable
  output logic serial_en,                       // Serial enable after reset
  input wire logic tx_serial,                   // Transmitter output bit
  output logic serial_out,                      // Serial output level
  output logic serial_oe,                       // Serial output enable
  input wire logic loopback,                    // Serial loopback mode
  input wire logic serial_in,                   // Serial input pin
  input wire logic rx_bit_clock,                // Receive clock pin
  input wire logic tx_bit_clock,                // Transmit clock pin
  output logic rx_data,                         // Receiver data after mux
  output logic rx_clock,                        // Receiver clock after mux
  input wire logic [7:0] rx_status,             // Receive status register
  input wire logic [7:0] tx_status,             // Transmit status register
  output logic rx_ready_n,                      // Receive ready, low
  output logic tx_ready_n                       // Transmit ready, low
);

  // Elaboration guard: the vector holds a four-bit channel number, so the count is fixed
  if (SOURCES != NUM_SOURCES) begin : g_bad_sources
    $error("host_bus_port serves exactly 16 sources");
  end

  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] ds_s;
    logic [1:0] ia_s;
    bus_state_e st;
    logic [7:0] dout;
    logic dout_oe;
    logic ack_n;
    logic ack_oe;
    logic chain_out_n;
    logic irq_oe;
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] vbr;
    logic taken;
    logic [CHAN_W-1:0] chan;
    logic clr;
    logic trun;
    logic [3:0] tout;
    logic [7:0] goe;
    logic sen;
    logic so;
    logic soe;
    logic rxd;
    logic rxc;
    logic rrdy_n;
    logic trdy_n;
  } port_state_s;

  port_state_s q;
  port_state_s d;

  // Highest numbered pending source wins
  function automatic logic [CHAN_W-1:0] top_channel(input logic [SOURCES-1:0] p);
    logic [CHAN_W-1:0] c;
    c = '0;
    for (int i = 0; i < SOURCES; i++) begin
      if (p[i]) c = CHAN_W'(i);
    end
    return c;
  endfunction

  logic cs_on;
  logic ds_on;
  logic ia_on;
  logic reg_cycle;
  logic int_ack_n_cycle;
  logic any_pend;

  // Synchronised, active-high views; only the second flop is looked at
  assign cs_on = ~q.cs_s[1];
  assign ds_on = ~q.ds_s[1];
  assign ia_on = ~q.ia_s[1];
  // A cycle with select and acknowledge both low is never started
  assign reg_cycle = cs_on & ds_on & ~ia_on;
  assign int_ack_n_cycle = ia_on & ds_on & ~cs_on;
  assign any_pend = |int_pending;

  // Next state of the whole port
  always_comb begin
    d = q;
    d.cs_s = {q.cs_s[0], chip_sel_n};
    d.ds_s = {q.ds_s[0], data_strobe_n};
    d.ia_s = {q.ia_s[0], int_ack_n};
    d.rd = 1'b0;
    d.wr = 1'b0;
    d.taken = 1'b0;
    d.clr = 1'b0;
    case (q.st)
      ST_IDLE: begin
        d.ack_oe = 1'b0;
        d.dout_oe = 1'b0;
        d.chain_out_n = 1'b1;
        if (reg_cycle) begin
          d.addr = reg_select;
          if (read_write) begin
            d.rd = 1'b1;
            d.st = ST_RD_LOAD;
          end else begin
            d.wr = 1'b1;
            d.wdata = data_in;
            if (reg_select == VEC_BASE_ADDR) d.vbr = data_in & VEC_BASE_WMASK;
            d.st = ST_WR_ACK;
          end
        end else if (int_ack_n_cycle && !chain_enable_in_n) begin
          if (any_pend) begin
            d.chan = top_channel(int_pending);
            d.st = ST_VEC_LOAD;
          end else begin
            d.chain_out_n = 1'b0;
            d.st = ST_PASS;
          end
        end
      end
      ST_RD_LOAD: begin
        // Data goes on the bus a cycle before acknowledge so it is settled
        d.dout = (q.addr == VEC_BASE_ADDR) ? q.vbr : reg_rdata;
        d.dout_oe = 1'b1;
        d.st = ST_RD_ACK;
      end
      ST_RD_ACK: begin
        d.ack_n = 1'b0;
        d.ack_oe = 1'b1;
        if (!(cs_on && ds_on)) begin
          d.ack_n = 1'b1;
          d.dout_oe = 1'b0;
          d.st = ST_RELEASE;
        end
      end
      ST_WR_ACK: begin
        d.ack_n = 1'b0;
        d.ack_oe = 1'b1;
        if (!(cs_on && ds_on)) begin
          d.ack_n = 1'b1;
          d.st = ST_RELEASE;
        end
      end
      ST_VEC_LOAD: begin
        d.dout = {q.vbr[7:VEC_HI_LSB], q.chan};
        d.dout_oe = 1'b1;
        d.taken = 1'b1;
        d.st = ST_VEC_ACK;
      end
      ST_VEC_ACK: begin
        d.ack_n = 1'b0;
        d.ack_oe = 1'b1;
        if (!(ia_on && ds_on)) begin
          d.ack_n = 1'b1;
          d.dout_oe = 1'b0;
          d.st = ST_RELEASE;
        end
      end
      ST_PASS: begin
        // Bus and acknowledge left alone while lower devices answer
        d.dout_oe = 1'b0;
        d.ack_oe = 1'b0;
        if (!(ia_on && ds_on)) begin
          d.chain_out_n = 1'b1;
          d.st = ST_IDLE;
        end
      end
      ST_RELEASE: begin
        // Ack was driven high last cycle; now let it float
        d.ack_oe = 1'b0;
        d.dout_oe = 1'b0;
        d.st = ST_IDLE;
      end
      default: d.st = ST_IDLE;
    endcase

    // Request held off the cycle after a vector so the cleared source can drop
    d.irq_oe = any_pend & ~q.taken & ~d.taken;

    // Side pins follow their sources outside reset
    d.trun = timer_run_req;
    d.tout = timer_out_in;
    d.goe = gpio_dir;
    d.sen = serial_en_req;
    d.so = tx_serial;
    d.soe = serial_en_req;
    // Loopback feeds the receiver from the transmitter side
    d.rxd = loopback ? tx_serial : serial_in;
    d.rxc = loopback ? tx_bit_clock : rx_bit_clock;
    d.rrdy_n = ~rx_status[READY_FLAG_BIT];
    d.trdy_n = ~tx_status[READY_FLAG_BIT];

    if (reset) begin
      d = '0;
      d.cs_s = 2'b11;
      d.ds_s = 2'b11;
      d.ia_s = 2'b11;
      d.st = ST_IDLE;
      d.ack_n = ACK_IDLE_LEVEL;
      d.chain_out_n = 1'b1;
      d.vbr = VEC_BASE_RESET;
      d.clr = 1'b1;
      d.trun = 1'b0;
      d.sen = 1'b0;
      d.soe = 1'b0;
      d.tout = 4'h0;
      d.goe = 8'h00;
      d.irq_oe = 1'b0;
      d.rrdy_n = 1'b1;
      d.trdy_n = ~tx_status[READY_FLAG_BIT];
    end
  end

  // One register stage for all state
  always_ff @(posedge clk_sys) begin
    q <= d;
  end

  assign data_out = q.dout;
  assign data_oe = q.dout_oe;
  assign transfer_ack_n = q.ack_n;
  assign transfer_ack_oe = q.ack_oe;
  assign chain_enable_out_n = q.chain_out_n;
  assign irq_out = 1'b0;
  assign irq_oe = q.irq_oe;
  assign reg_rd = q.rd;
  assign reg_wr = q.wr;
  assign reg_addr = q.addr;
  assign reg_wdata = q.wdata;
  assign vector_base_reg = q.vbr;
  assign vec_taken = q.taken;
  assign vec_channel = q.chan;
  assign core_clear = q.clr;
  assign timer_run = q.trun;
  assign timer_out = q.tout;
  assign gpio_oe = q.goe;
  assign serial_en = q.sen;
  assign serial_out = q.so;
  assign serial_oe = q.soe;
  assign rx_data = q.rxd;
  assign rx_clock = q.rxc;
  assign rx_ready_n = q.rrdy_n;
  assign tx_ready_n = q.trdy_n;

  // Checks on the port's own outputs
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_read_data_first: assert property (q.st == ST_RD_ACK && !q.ack_n && q.ack_oe |-> q.dout_oe
    && $past(q.dout_oe)) else $error("Read acknowledge without data driven first");

  a_read_end_float: assert property (q.st == ST_RD_ACK && !(cs_on && ds_on)
    |=> q.ack_n && q.ack_oe && !q.dout_oe ##1 !q.ack_oe) else $error("Read end did not release");

  a_write_strobe_ack: assert property (q.wr |-> q.st == ST_WR_ACK ##1 !q.ack_n && q.ack_oe)
    else $error("Write not followed by acknowledge");

  a_write_end_float: assert property (q.st == ST_WR_ACK && !(cs_on && ds_on)
    |=> q.ack_n && q.ack_oe ##1 !q.ack_oe) else $error("Write end did not release");

  a_irq_follows: assert property ($past(any_pend) && !$past(reset) && !q.taken && !$past(q.taken)
    |-> q.irq_oe) else $error("Pending source without request");

  a_vector_value: assert property (q.st == ST_VEC_ACK && q.dout_oe
    |-> q.dout == {q.vbr[7:VEC_HI_LSB], q.chan}) else $error("Wrong vector on bus");

  a_vector_top: assert property (q.st == ST_IDLE && int_ack_n_cycle && !chain_enable_in_n && any_pend
    |=> q.chan == top_channel($past(int_pending)) ##1 q.taken) else $error("Vector not highest channel");

  a_int_ack_n_end_float: assert property (q.st == ST_VEC_ACK && !(ia_on && ds_on)
    |=> q.ack_n && !q.dout_oe ##1 !q.ack_oe) else $error("Acknowledge end did not release");

  a_taken_drops_irq: assert property (q.taken |-> !q.irq_oe ##1 !q.irq_oe)
    else $error("Request not released after vector");

  a_pass_chain: assert property (q.st == ST_IDLE && int_ack_n_cycle && !chain_enable_in_n && !any_pend
    |=> !q.chain_out_n) else $error("Chain enable out not asserted");

  a_pass_quiet: assert property (!q.chain_out_n |-> !q.dout_oe && !q.ack_oe)
    else $error("Driving bus while passing chain");

  a_ready_mirror: assert property (##1 rx_ready_n == !$past(rx_status[READY_FLAG_BIT])
    && tx_ready_n == !$past(tx_status[READY_FLAG_BIT])) else $error("Ready pins do not mirror status");

  a_loop_select: assert property (loopback |=> rx_data == $past(tx_serial)
    && rx_clock == $past(tx_bit_clock)) else $error("Loopback uses external receive pins");

  a_sync_delay: assert property (q.wr || q.rd
    |-> !$past(chip_sel_n, 3) && !$past(data_strobe_n, 3)) else $error("Access started without synchronised select");

  a_reset_state: assert property (disable iff (1'b0) reset |=> q.vbr == VEC_BASE_RESET
    && !q.soe && !q.trun && q.goe == 8'h00 && q.tout == 4'h0 && !q.irq_oe && q.clr)
    else $error("Reset state wrong");

endmodule
`default_nettype wire

// File: shared/host_port_pkg.sv
// Constants and types shared by the asynchronous host bus port
`default_nettype none
package host_port_pkg;
  // Register select address of the vector base register
  localparam logic [4:0] VEC_BASE_ADDR = 5'h17;
  // Vector base reset value and writable bits (bits 2..0 read zero)
  localparam logic [7:0] VEC_BASE_RESET = 8'h00;
  localparam logic [7:0] VEC_BASE_WMASK = 8'hf8;
  // Field position of the upper vector nibble
  localparam int VEC_HI_LSB = 4;
  // Status bit that both ready flags mirror
  localparam int READY_FLAG_BIT = 7;
  // Reset level of the acknowledge pin
  localparam logic ACK_IDLE_LEVEL = 1'b1;
  // Least reset hold time and its cycle count at the system clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_MIN_NS = 2000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Number of interrupt sources and width of a channel number
  localparam int NUM_SOURCES = 16;
  localparam int CHAN_W = 4;

  // Bus cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_LOAD,
    ST_RD_ACK,
    ST_WR_ACK,
    ST_VEC_LOAD,
    ST_VEC_ACK,
    ST_PASS,
    ST_RELEASE
  } bus_state_e;
endpackage
`default_nettype wire

// File: tb/async_host_bus_int_ack_n_reset_tb.sv
// Self-checking bench for the host bus port
`default_nettype none
module async_host_bus_int_ack_n_reset_tb import host_port_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset, chip_sel_n, data_strobe_n, read_write, int_ack_n, chain_enable_in_n;
  logic [4:0] reg_select, reg_addr, wa, ra;
  logic [7:0] data_in, data_out, reg_wdata, reg_rdata, vector_base_reg, gpio_dir, gpio_oe, rx_status, tx_status, wd;
  logic data_oe, transfer_ack_n, transfer_ack_oe, chain_enable_out_n, irq_out, irq_oe, reg_rd, reg_wr, vec_taken;
  logic core_clear, timer_run_req, timer_run, serial_en_req, serial_en, tx_serial, serial_out, serial_oe, loopback;
  logic serial_in, rx_bit_clock, tx_bit_clock, rx_data, rx_clock, rx_ready_n, tx_ready_n, chain_seen, drive_seen;
  logic [15:0] int_pending;
  logic [3:0] vec_channel, timer_out_in, timer_out;
  int errors, samples_checked;

  host_bus_port i_host_bus_port (.clk_sys(clk_sys), .reset(reset), .chip_sel_n(chip_sel_n),
    .data_strobe_n(data_strobe_n), .read_write(read_write), .reg_select(reg_select), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .transfer_ack_n(transfer_ack_n), .transfer_ack_oe(transfer_ack_oe),
    .int_ack_n(int_ack_n), .chain_enable_in_n(chain_enable_in_n), .chain_enable_out_n(chain_enable_out_n),
    .irq_out(irq_out), .irq_oe(irq_oe), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .vector_base_reg(vector_base_reg), .int_pending(int_pending),
    .vec_taken(vec_taken), .vec_channel(vec_channel), .core_clear(core_clear), .timer_run_req(timer_run_req),
    .timer_run(timer_run), .timer_out_in(timer_out_in), .timer_out(timer_out), .gpio_dir(gpio_dir),
    .gpio_oe(gpio_oe), .serial_en_req(serial_en_req), .serial_en(serial_en), .tx_serial(tx_serial),
    .serial_out(serial_out), .serial_oe(serial_oe), .loopback(loopback), .serial_in(serial_in),
    .rx_bit_clock(rx_bit_clock), .tx_bit_clock(tx_bit_clock), .rx_data(rx_data), .rx_clock(rx_clock),
    .rx_status(rx_status), .tx_status(tx_status), .rx_ready_n(rx_ready_n), .tx_ready_n(tx_ready_n));

  host_master i_host_master (.clk_sys(clk_sys), .chip_sel_n(chip_sel_n), .data_strobe_n(data_strobe_n),
    .read_write(read_write), .reg_select(reg_select), .data_in(data_in), .int_ack_n(int_ack_n),
    .data_out(data_out), .transfer_ack_n(transfer_ack_n), .transfer_ack_oe(transfer_ack_oe));

  // Register file stand-in: contents derived from the address so every read is predictable
  assign reg_rdata = {3'h5, reg_addr};

  // Strobe capture at mid-cycle, where the one-cycle pulses have settled
  always @(negedge clk_sys) begin
    if (reg_wr === 1'b1) begin
      wa <= reg_addr;
      wd <= reg_wdata;
    end
    if (reg_rd === 1'b1) ra <= reg_addr;
  end

  // Chain and drive watch
  always @(posedge clk_sys) begin
    if (chain_enable_out_n === 1'b0) chain_seen <= 1'b1;
    if (data_oe === 1'b1 || transfer_ack_oe === 1'b1) drive_seen <= 1'b1;
  end

  // Interrupt logic stand-in drops the channel whose vector was taken
  always @(negedge clk_sys) begin
    if (vec_taken === 1'b1) int_pending[vec_channel] <= 1'b0;
  end

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One master cycle, then a settle gap; ack outcome, read data and release of data, acknowledge and chain out are judged
  task automatic cyc(input int kind, input logic [4:0] a, input logic [7:0] wdat, input logic [7:0] exp,
                     input logic ack);
    logic [7:0] rd;
    logic got;
    chain_seen = 1'b0;
    drive_seen = 1'b0;
    i_host_master.run(kind, a, wdat, rd, got);
    repeat (6) @(negedge clk_sys);
    chk({got, (kind == 1 || !ack) ? 8'h00 : rd}, {ack, (kind == 1 || !ack) ? 8'h00 : exp});
    chk({data_oe, transfer_ack_oe, chain_enable_out_n}, 3'b001);
  endtask

  // Ready mirrors and loopback mux in both settings, other side pins with loopback off
  task automatic side_pins();
    {loopback, serial_in, rx_bit_clock, tx_serial, tx_bit_clock} = 5'b01001;
    {rx_status, tx_status} = 16'h8000;
    repeat (2) @(negedge clk_sys);
    chk({rx_data, rx_clock, rx_ready_n, tx_ready_n, serial_out, irq_out}, 6'b100100);
    chk({timer_run, timer_out, gpio_oe, serial_oe, serial_en}, {1'b1, 4'ha, 8'h5c, 2'b11});
    {loopback, serial_in, tx_serial, rx_status, tx_status} = {2'b10, 1'b1, 16'h0080};
    repeat (2) @(negedge clk_sys);
    chk({rx_data, rx_clock, rx_ready_n, tx_ready_n, serial_out}, 5'b11101);
  endtask

  // Plain and vector base writes and reads back to back
  task automatic reg_cycles();
    cyc(1, 5'h05, 8'h3c, 8'h00, 1'b1);
    chk({wa, wd}, {5'h05, 8'h3c});
    cyc(0, 5'h03, 8'h00, 8'ha3, 1'b1);
    chk(ra, 5'h03);
    cyc(1, VEC_BASE_ADDR, 8'hbd, 8'h00, 1'b1);
    chk(vector_base_reg, 8'hb8);
    cyc(0, VEC_BASE_ADDR, 8'h00, 8'hb8, 1'b1);
  endtask

  // Vectors by priority, request release, chain pass and disabled chain
  task automatic int_ack_n_cycles();
    int_pending = 16'h0024;
    repeat (3) @(negedge clk_sys);
    chk(irq_oe, 1'b1);
    cyc(2, 5'h00, 8'h00, 8'hb5, 1'b1);
    chk({int_pending, irq_oe}, {16'h0004, 1'b1});
    cyc(2, 5'h00, 8'h00, 8'hb2, 1'b1);
    chk(irq_oe, 1'b0);
    cyc(2, 5'h00, 8'h00, 8'h00, 1'b0);
    chk({chain_seen, drive_seen}, 2'b10);
    chain_enable_in_n = 1'b1;
    int_pending = 16'h0100;
    cyc(2, 5'h00, 8'h00, 8'h00, 1'b0);
    chk({chain_seen, drive_seen, int_pending}, {2'b00, 16'h0100});
    chain_enable_in_n = 1'b0;
  endtask

  // Long reset with side requests active; afterwards the zero base gives vector 0f
  task automatic reset_hold();
    int_pending = 16'h8000;
    tx_status = 8'h80;
    reset = 1'b1;  // Held for the full minimum time
    repeat (3) @(negedge clk_sys);
    chk({timer_run, timer_out, gpio_oe, serial_oe, serial_en}, 15'h0000);
    chk({vector_base_reg, core_clear, irq_oe, rx_ready_n, tx_ready_n}, {8'h00, 4'b1010});
    chk({data_oe, transfer_ack_oe, chain_enable_out_n}, 3'b001);
    repeat (RESET_MIN_CYC - 3) @(negedge clk_sys);
    reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(core_clear, 1'b0);
    cyc(2, 5'h00, 8'h00, 8'h0f, 1'b1);
  endtask

  task automatic close_out();
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    errors = 0;
    samples_checked = 0;
    reset = 1'b1;
    chain_enable_in_n = 1'b0;
    int_pending = 16'h0000;
    {timer_run_req, timer_out_in, gpio_dir, serial_en_req} = {1'b1, 4'ha, 8'h5c, 1'b1};
    {loopback, serial_in, rx_bit_clock, tx_serial, tx_bit_clock} = 5'b00000;
    {rx_status, tx_status} = 16'h0000;
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    side_pins();
    reg_cycles();
    int_ack_n_cycles();
    reset_hold();
    close_out();
  end

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #200000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire

// File: tb/host_master.sv
// Bus master model that runs register and acknowledge cycles on the host port
`default_nettype none
module host_master (
  input wire logic clk_sys,         // System clock
  output logic chip_sel_n,          // Chip select, low
  output logic data_strobe_n,       // Data strobe, low
  output logic read_write,          // High read, low write
  output logic [4:0] reg_select,    // Register select
  output logic [7:0] data_in,       // Write data
  output logic int_ack_n,           // Interrupt acknowledge, low
  input wire logic [7:0] data_out,  // Device data
  input wire logic transfer_ack_n,  // Acknowledge level
  input wire logic transfer_ack_oe  // Acknowledge driven
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    chip_sel_n = 1'b1;
    data_strobe_n = 1'b1;
    int_ack_n = 1'b1;
    read_write = 1'b1;
    reg_select = 5'h00;
    data_in = 8'h00;
  end

  // One cycle: kind 0 read, 1 write, 2 acknowledge; a cycle nobody answers is dropped after a bound
  task automatic run(input int kind, input logic [4:0] addr, input logic [7:0] wdata,
                     output logic [7:0] rdata, output logic acked);
    int n;
    @(negedge clk_sys);  // Changes only off the sampling edge, all lines together
    read_write = (kind != 1);
    reg_select = addr;
    data_in = wdata;
    int_ack_n = (kind != 2);  // Select and acknowledge never low together
    chip_sel_n = (kind == 2);
    data_strobe_n = 1'b0;
    acked = 1'b0;
    rdata = 8'h00;
    for (n = 0; n < 12 && !acked; n++) begin
      @(negedge clk_sys);  // Mid-cycle look: the reply launched at the last rising edge has settled
      if (transfer_ack_oe === 1'b1 && transfer_ack_n === 1'b0) begin
        acked = 1'b1;
        rdata = data_out;  // Data taken only once the acknowledge stands
      end
    end
    data_strobe_n = 1'b1;  // Strobe negation ends the cycle
    chip_sel_n = 1'b1;
    int_ack_n = 1'b1;
    data_in = ~wdata;  // Released bus shows no stale value
  endtask
endmodule
`default_nettype wire
